// ===== common/cal_cfg_pkg.sv
// Constants for the oscillator calibration and monitor converter register bank
package cal_cfg_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] ADDR_COUNT_CFG = 8'h23;
    localparam logic [7:0] ADDR_CLOCK_REDUCE = 8'h24;
    localparam logic [7:0] ADDR_DIV_BUF = 8'h25;
    localparam logic [7:0] ADDR_BAND_TIME = 8'h26;
    localparam logic [7:0] ADDR_SETTLE_LO = 8'h27;
    localparam logic [7:0] ADDR_SETTLE_HI = 8'h28;
    localparam logic [7:0] ADDR_LEVEL_LO = 8'h29;
    localparam logic [7:0] ADDR_LEVEL_HI = 8'h2A;
    localparam logic [7:0] ADDR_RSVD_A = 8'h2B;
    localparam logic [7:0] ADDR_RSVD_B = 8'h2C;
    localparam logic [7:0] ADDR_MON_DIV = 8'h2D;
    localparam logic [7:0] ADDR_MON_CTRL = 8'h2E;
    localparam int NUM_REGS = 12;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    localparam int BIT_COUNT_SEL = 7;
    localparam int BIT_CLOCK_HALVING = 2;
    localparam int BIT_OUT_DIV_DBUF = 7;
    localparam int BIT_CAL_DIV_DBUF = 6;
    localparam int BIT_OSC_DBUF = 7;
    localparam int BIT_DELAY_DBUF = 7;
    localparam int BIT_CONV_EN = 7;
    localparam int BIT_ADC_EN = 1;
    localparam int BIT_AUTO_CONV = 0;
    localparam int TIMEOUT_W = 15;
    localparam int TIMEOUT_HI_W = 7;
endpackage : cal_cfg_pkg

// ===== hw/cal_cfg_reg.sv
// One 8-bit read/write register cell with synchronous reset
`timescale 1ns/10ps
module cal_cfg_reg #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [WIDTH-1:0] wr_data,
    output logic [WIDTH-1:0] value_q
);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            value_q <= RESET_VAL;
        end else if (wr_en) begin
            value_q <= wr_data;
        end
    end
endmodule : cal_cfg_reg

// ===== hw/cal_cfg_regs.sv
// Register bank configuring oscillator calibration and the monitor converter
`timescale 1ns/10ps
// Overview of operation
// - Bit 7 at 0x23 selects calibration count
// - Halving bit halves both calibration clocks
// - 0x25 bit 7 buffers output divider
// - 0x25 bit 6 buffers calibration dividers
// - 0x26 sets band decision time
// - Settle timeout spans 0x27 and 0x28
// - 0x28 bit 7 buffers oscillator overrides
// - Level timeout spans 0x29 and 0x2A
// - 0x2A bit 7 buffers delay fields
// - 0x2D sets monitor converter clock divider
// - 0x2E bit 7 enables conversions
// - 0x2E bit 1 enables converter
// - All registers reset to zero, readable
// - Auto bit starts conversion at calibration
module cal_cfg_regs
    import cal_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [cal_cfg_pkg::ADDR_W-1:0] addr,
    input wire logic [cal_cfg_pkg::DATA_W-1:0] wr_data,
    input wire logic cal_start,
    input wire logic start_conversion,
    output logic [cal_cfg_pkg::DATA_W-1:0] rd_data,
    output logic rd_valid,
    output logic cal_count_select,
    output logic cal_clock_halving,
    output logic out_divider_dbuf_en,
    output logic cal_divider_dbuf_en,
    output logic osc_override_dbuf_en,
    output logic delay_ctrl_dbuf_en,
    output logic [cal_cfg_pkg::DATA_W-1:0] band_decision_time,
    output logic [cal_cfg_pkg::TIMEOUT_W-1:0] dac_settle_timeout,
    output logic [cal_cfg_pkg::TIMEOUT_W-1:0] level_control_timeout,
    output logic [cal_cfg_pkg::DATA_W-1:0] monitor_clock_divider,
    output logic conversion_enable,
    output logic converter_enable,
    output logic auto_conversion_on_cal,
    output logic conversion_start
);
    import cal_cfg_pkg::*;

    localparam logic [7:0] BASE_ADDR = ADDR_COUNT_CFG;

    logic [DATA_W-1:0] regs [NUM_REGS];
    logic [NUM_REGS-1:0] sel;

    // One cell per address; reserved cells store too so reads return the host's value
    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
            assign sel[gi] = wr_en && (addr == BASE_ADDR + 8'(gi));
            cal_cfg_reg #(
                .WIDTH(DATA_W),
                .RESET_VAL(RESET_VALUE)
            ) u_reg (
                .clk(clk),
                .rst_n(rst_n),
                .wr_en(sel[gi]),
                .wr_data(wr_data),
                .value_q(regs[gi])
            );
        end
    endgenerate

    function automatic int idx(input logic [7:0] a);
        return int'(a - BASE_ADDR);
    endfunction : idx

    // Decoded fields registered so every output leaves a flip-flop
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cal_count_select <= 1'b0;
            cal_clock_halving <= 1'b0;
            out_divider_dbuf_en <= 1'b0;
            cal_divider_dbuf_en <= 1'b0;
            osc_override_dbuf_en <= 1'b0;
            delay_ctrl_dbuf_en <= 1'b0;
            band_decision_time <= RESET_VALUE;
            dac_settle_timeout <= '0;
            level_control_timeout <= '0;
            monitor_clock_divider <= RESET_VALUE;
            conversion_enable <= 1'b0;
            converter_enable <= 1'b0;
            auto_conversion_on_cal <= 1'b0;
        end else begin
            cal_count_select <= regs[idx(ADDR_COUNT_CFG)][BIT_COUNT_SEL];
            cal_clock_halving <= regs[idx(ADDR_CLOCK_REDUCE)][BIT_CLOCK_HALVING];
            out_divider_dbuf_en <= regs[idx(ADDR_DIV_BUF)][BIT_OUT_DIV_DBUF];
            cal_divider_dbuf_en <= regs[idx(ADDR_DIV_BUF)][BIT_CAL_DIV_DBUF];
            osc_override_dbuf_en <= regs[idx(ADDR_SETTLE_HI)][BIT_OSC_DBUF];
            delay_ctrl_dbuf_en <= regs[idx(ADDR_LEVEL_HI)][BIT_DELAY_DBUF];
            band_decision_time <= regs[idx(ADDR_BAND_TIME)];
            dac_settle_timeout <= {regs[idx(ADDR_SETTLE_HI)][TIMEOUT_HI_W-1:0],
                                   regs[idx(ADDR_SETTLE_LO)]};
            level_control_timeout <= {regs[idx(ADDR_LEVEL_HI)][TIMEOUT_HI_W-1:0],
                                      regs[idx(ADDR_LEVEL_LO)]};
            monitor_clock_divider <= regs[idx(ADDR_MON_DIV)];
            conversion_enable <= regs[idx(ADDR_MON_CTRL)][BIT_CONV_EN];
            converter_enable <= regs[idx(ADDR_MON_CTRL)][BIT_ADC_EN];
            auto_conversion_on_cal <= regs[idx(ADDR_MON_CTRL)][BIT_AUTO_CONV];
        end
    end

    // Start pulse: start_conversion input in any mode, calibration start only in auto mode.
    // Gated by the stored enables so a disabled converter never sees a start.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            conversion_start <= 1'b0;
        end else begin
            conversion_start <= conversion_enable && converter_enable &&
                                (start_conversion || (cal_start && auto_conversion_on_cal));
        end
    end

    // Read port: one cycle latency, unmapped addresses read zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_data <= RESET_VALUE;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_en;
            if (!rd_en) begin
                rd_data <= rd_data;
            end else if (addr >= ADDR_COUNT_CFG && addr <= ADDR_MON_CTRL) begin
                rd_data <= regs[idx(addr)];
            end else begin
                rd_data <= RESET_VALUE;
            end
        end
    end
endmodule : cal_cfg_regs

// ===== bench/cal_cfg_regs_asserts.sv
// Port assertions for the calibration config register bank
`timescale 1ns/10ps
module cal_cfg_regs_asserts (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic cal_start,
    input wire logic start_conversion,
    input wire logic cal_count_select,
    input wire logic [14:0] dac_settle_timeout,
    input wire logic [14:0] level_control_timeout,
    input wire logic conversion_enable,
    input wire logic converter_enable,
    input wire logic auto_conversion_on_cal,
    input wire logic conversion_start
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire logic due = (start_conversion || cal_start && auto_conversion_on_cal) && conversion_enable && converter_enable;
    a_count_select: assert property (wr_en && addr == 8'h23 |=> ##1 cal_count_select == $past(wr_data[7], 2))
        else $error("count select");
    a_settle_low: assert property (wr_en && addr == 8'h27 |=> ##1 dac_settle_timeout[7:0] == $past(wr_data, 2))
        else $error("settle low");
    a_settle_high: assert property (wr_en && addr == 8'h28 |=> ##1 dac_settle_timeout[14:8] == $past(wr_data[6:0], 2))
        else $error("settle high");
    a_level_low: assert property (wr_en && addr == 8'h29 |=> ##1 level_control_timeout[7:0] == $past(wr_data, 2))
        else $error("level low");
    a_level_high: assert property (wr_en && addr == 8'h2A |=> ##1 level_control_timeout[14:8] == $past(wr_data[6:0], 2))
        else $error("level high");
    a_conv_pulse: assert property (due |=> conversion_start)
        else $error("missing start");
    a_conv_quiet: assert property (!due |=> !conversion_start)
        else $error("stray start");
    a_reset_zero: assert property ($rose(rst_n) |-> dac_settle_timeout == 15'h0000 && !conversion_start)
        else $error("not reset");
endmodule : cal_cfg_regs_asserts

// ===== bench/cal_cfg_host.sv
// Host model driving the register bank strobes
`timescale 1ns/10ps
module cal_cfg_host (
    input wire logic clk,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    output logic wr_en = 1'b0,
    output logic rd_en = 1'b0,
    output logic [7:0] addr = 8'h00,
    output logic [7:0] wr_data = 8'h00
);
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        // Released data flips so stale bytes never look valid
        wr_data <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        // Data is taken at the edge where the valid pulse is seen high
        do begin
            @(posedge clk);
        end while (rd_valid !== 1'b1);
        d = rd_data;
    endtask : rd
endmodule : cal_cfg_host

// ===== bench/cal_cfg_regs_bench.sv
// Self-checking bench for the calibration config register bank
`timescale 1ns/10ps
module cal_cfg_regs_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cal_start = 1'b0;
    logic start_conversion = 1'b0;
    logic wr_en, rd_en, rd_valid, conversion_start;
    logic [7:0] addr, wr_data, rd_data, got;
    wire logic [54:0] f;
    int n_fail = 0;
    int checks_done = 0;
    // Address, write data, expected readback; 0x22 and 0x40 are unmapped
    logic [23:0] rows [14] = '{24'h22AA00, 24'h238080, 24'h240404, 24'h25C0C0, 24'h26A5A5, 24'h27FFFF,
        24'h28FFFF, 24'h290101, 24'h2A8080, 24'h2B5A5A, 24'h2C3C3C, 24'h2D8181, 24'h2E8383, 24'h405500};
    always #5 clk = ~clk;
    cal_cfg_host cal_cfg_host_i (.clk, .rd_data, .rd_valid, .wr_en, .rd_en, .addr, .wr_data);
    cal_cfg_regs cal_cfg_regs_i (.clk, .rst_n, .wr_en, .rd_en, .addr, .wr_data, .cal_start, .start_conversion,
        .rd_data, .rd_valid, .cal_count_select(f[54]), .cal_clock_halving(f[53]), .out_divider_dbuf_en(f[52]),
        .cal_divider_dbuf_en(f[51]), .osc_override_dbuf_en(f[50]), .delay_ctrl_dbuf_en(f[49]),
        .band_decision_time(f[48:41]), .dac_settle_timeout(f[40:26]), .level_control_timeout(f[25:11]),
        .monitor_clock_divider(f[10:3]), .conversion_enable(f[2]), .converter_enable(f[1]),
        .auto_conversion_on_cal(f[0]), .conversion_start);
    task automatic chk(input string name, input logic [54:0] exp, input logic [54:0] seen);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic fire(input logic sc, input logic cs, input logic exp);
        @(posedge clk);
        start_conversion <= sc;
        cal_start <= cs;
        @(posedge clk);
        start_conversion <= 1'b0;
        cal_start <= 1'b0;
        #1 chk("conversion_start", 55'(exp), 55'(conversion_start));
    endtask : fire
    task automatic results;
        if (n_fail == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        #1 chk("reset fields", '0, f);
        foreach (rows[i]) begin
            cal_cfg_host_i.wr(rows[i][23:16], rows[i][15:8]);
            cal_cfg_host_i.rd(rows[i][23:16], got);
            chk("readback", 55'(rows[i][7:0]), 55'(got));
        end
        chk("fields", {6'h3F, 8'hA5, 15'h7FFF, 15'h0001, 8'h81, 3'h7}, f);
        fire(1'b1, 1'b0, 1'b1);
        fire(1'b0, 1'b1, 1'b1);
        cal_cfg_host_i.wr(8'h2E, 8'h82);
        fire(1'b0, 1'b1, 1'b0);
        cal_cfg_host_i.wr(8'h2E, 8'h03);
        fire(1'b1, 1'b0, 1'b0);
        cal_cfg_host_i.wr(8'h2E, 8'h81);
        fire(1'b1, 1'b0, 1'b0);
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        #1 chk("fields after reset", '0, f);
        cal_cfg_host_i.rd(8'h26, got);
        chk("readback after reset", '0, 55'(got));
        results();
    end
    initial begin
        repeat (2000) @(posedge clk);
        n_fail++;
        results();
    end
endmodule : cal_cfg_regs_bench
bind cal_cfg_regs cal_cfg_regs_asserts cal_cfg_regs_asserts_i (.*);
